// ==== hw/ctc_params.svh ====
`ifndef CTC_PARAMS_SVH
`define CTC_PARAMS_SVH

`define CTC_NCONTACT        8
`define CTC_NLED            8
`define CTC_NMON            8
`define CTC_AR_RELAY        2
`define CTC_CLK_HZ          100000000
`define CTC_LAMP_SEC        2
`define CTC_LAMP_CYC        (`CTC_CLK_HZ * `CTC_LAMP_SEC)
`define CTC_LAMP_W          28

`define CTC_ADDR_MODE       12'h000
`define CTC_ADDR_PATTERN    12'h004
`define CTC_ADDR_CMD        12'h008
`define CTC_ADDR_STATUS     12'h00c
`define CTC_ADDR_RELAY      12'h010
`define CTC_ADDR_PROT       12'h014
`define CTC_ADDR_MON        12'h018
`define CTC_ADDR_ROUTE      12'h01c

`define CTC_CMD_CT_LSB      0
`define CTC_CMD_LED_BIT     2
`define CTC_CMD_AR_BIT      3
`define CTC_ST_LAMP_BIT     0
`define CTC_ST_AR_BIT       1
`define CTC_ST_HELD_BIT     2
`define CTC_ROUTE_RST       1'b1

`endif

// ==== hw/ctc_pkg.sv ====
package ctc_pkg;
  typedef enum logic [1:0] {
    CTC_MODE_DISABLED,
    CTC_MODE_TEST,
    CTC_MODE_BLOCKED
  } ctc_mode_t;

  typedef enum logic [1:0] {
    CTC_CT_NOP,
    CTC_CT_APPLY,
    CTC_CT_REMOVE
  } ctc_ct_cmd_t;

  typedef enum logic [1:0] {
    CTC_AR_IDLE,
    CTC_AR_TRIP,
    CTC_AR_RECLOSE
  } ctc_ar_state_t;
endpackage

// ==== hw/ctc_lamp_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ctc_params.svh"

module ctc_lamp_timer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      lamp_on
);

  typedef struct packed {
    logic                   on;
    logic [`CTC_LAMP_W-1:0] cnt;
  } ctc_lamp_st_t;

  parameter int unsigned LAMP_CYC = `CTC_LAMP_CYC;

  ctc_lamp_st_t st;
  ctc_lamp_st_t next_st;

  always_comb begin
    next_st = st;
    if (start) begin
      // a new request restarts the full interval
      next_st.on  = 1'b1;
      next_st.cnt = `CTC_LAMP_W'(LAMP_CYC - 1);
    end else if (st.on) begin
      if (st.cnt == '0) begin
        next_st.on = 1'b0;
      end else begin
        next_st.cnt = st.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lamp_on = st.on;

endmodule
`default_nettype wire

// ==== hw/ctc_top.sv ====
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ctc_params.svh"

module ctc_top #(
  parameter int unsigned LAMP_CYC = `CTC_LAMP_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [`CTC_NCONTACT-1:0]  prot_contacts,
  input  wire logic [`CTC_NLED-1:0]      prot_leds,
  input  wire logic [`CTC_NMON-1:0]      mon_signals,
  input  wire logic                      reclose_trip_done,
  input  wire logic                      reclose_avail,
  output logic [`CTC_NCONTACT-1:0]       relay_drive,
  output logic [`CTC_NLED-1:0]           led_drive,
  output logic [`CTC_NMON-1:0]           monitor_out,
  output logic                           reclose_trip_check_signal,
  output logic                           prot_disabled
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ctc_pkg::ctc_mode_t         mode;
    logic [`CTC_NCONTACT-1:0]   pattern;
    logic [`CTC_NCONTACT-1:0]   held;
    logic                       test_on;
    ctc_pkg::ctc_ar_state_t     ar;
    logic                       route_ok;
    logic [31:0]                rdata;
    logic [`CTC_NCONTACT-1:0]   relay;
    logic [`CTC_NLED-1:0]       led;
    logic [`CTC_NMON-1:0]       mon;
    logic                       trip;
  } ctc_state_t;

  ctc_state_t st;
  ctc_state_t next_st;

  logic wr;
  logic rd;
  logic lamp_start;
  logic lamp_on;
  logic bad_addr;
  ctc_pkg::ctc_ct_cmd_t ct_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;

  always_comb begin
    case (paddr)
      `CTC_ADDR_MODE, `CTC_ADDR_PATTERN, `CTC_ADDR_CMD, `CTC_ADDR_STATUS,
      `CTC_ADDR_RELAY, `CTC_ADDR_PROT, `CTC_ADDR_MON, `CTC_ADDR_ROUTE: bad_addr = 1'b0;
      default: bad_addr = 1'b1;
    endcase
  end
  assign pslverr = psel && penable && bad_addr;

  // command word is a write-only strobe; reads return zero, i.e. no-operation
  assign ct_cmd = ctc_pkg::ctc_ct_cmd_t'(pwdata[`CTC_CMD_CT_LSB +: 2]);
  assign lamp_start = wr && (paddr == `CTC_ADDR_CMD) && pwdata[`CTC_CMD_LED_BIT];

  ctc_lamp_timer #(
    .LAMP_CYC (LAMP_CYC)
  ) u_lamp (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (lamp_start),
    .lamp_on (lamp_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;

    if (wr) begin
      case (paddr)
        `CTC_ADDR_MODE: begin
          next_st.mode = ctc_pkg::ctc_mode_t'(pwdata[1:0]);
        end
        `CTC_ADDR_PATTERN: begin
          if (st.mode == ctc_pkg::CTC_MODE_BLOCKED) begin
            next_st.pattern = pwdata[`CTC_NCONTACT-1:0];
          end
        end
        `CTC_ADDR_CMD: begin
          // fields are pulses: nothing is stored, so each reads back as nop
          if (st.mode == ctc_pkg::CTC_MODE_BLOCKED) begin
            case (ct_cmd)
              ctc_pkg::CTC_CT_APPLY: begin
                next_st.held    = st.pattern;
                next_st.test_on = 1'b1;
              end
              ctc_pkg::CTC_CT_REMOVE: begin
                next_st.held    = '0;
                next_st.test_on = 1'b0;
              end
              default: begin
              end
            endcase
          end
          if (pwdata[`CTC_CMD_AR_BIT] && reclose_avail && st.route_ok
              && st.ar == ctc_pkg::CTC_AR_IDLE) begin
            next_st.ar = ctc_pkg::CTC_AR_TRIP;
          end
        end
        `CTC_ADDR_ROUTE: begin
          next_st.route_ok = pwdata[0];
        end
        default: begin
        end
      endcase
    end

    // leaving contacts-blocked drops any applied test
    if (st.mode != ctc_pkg::CTC_MODE_BLOCKED) begin
      next_st.held    = '0;
      next_st.test_on = 1'b0;
    end

    // one trip pulse per command; a reissue while the sequence is busy is ignored
    case (st.ar)
      ctc_pkg::CTC_AR_IDLE: begin
        next_st.trip = 1'b0;
      end
      ctc_pkg::CTC_AR_TRIP: begin
        next_st.trip = st.route_ok;
        next_st.ar   = ctc_pkg::CTC_AR_RECLOSE;
      end
      ctc_pkg::CTC_AR_RECLOSE: begin
        next_st.trip = 1'b0;
        if (reclose_trip_done) begin
          next_st.ar = ctc_pkg::CTC_AR_IDLE;
        end
      end
      default: begin
        next_st.ar = ctc_pkg::CTC_AR_IDLE;
      end
    endcase

    if (rd) begin
      case (paddr)
        `CTC_ADDR_MODE:    next_st.rdata = {30'h0, st.mode};
        `CTC_ADDR_PATTERN: next_st.rdata = {{(32-`CTC_NCONTACT){1'b0}}, st.pattern};
        `CTC_ADDR_STATUS: begin
          next_st.rdata[`CTC_ST_LAMP_BIT] = lamp_on;
          next_st.rdata[`CTC_ST_AR_BIT]   = (st.ar != ctc_pkg::CTC_AR_IDLE);
          next_st.rdata[`CTC_ST_HELD_BIT] = st.test_on;
        end
        // intended contact states, not what the relays actually do
        `CTC_ADDR_RELAY:   next_st.rdata = {{(32-`CTC_NCONTACT){1'b0}}, prot_contacts};
        `CTC_ADDR_PROT:    next_st.rdata = {{(32-`CTC_NLED){1'b0}}, st.led};
        `CTC_ADDR_MON:     next_st.rdata = {{(32-`CTC_NMON){1'b0}}, st.mon};
        `CTC_ADDR_ROUTE:   next_st.rdata = {31'h0, st.route_ok};
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end else begin
      next_st.rdata = st.rdata;
    end

    // outputs registered
    case (st.mode)
      ctc_pkg::CTC_MODE_DISABLED: next_st.relay = prot_contacts;
      ctc_pkg::CTC_MODE_TEST:     next_st.relay = '0;
      // protection is blocked here, so only the applied pattern and the or-ed trip-check relay operate contacts
      ctc_pkg::CTC_MODE_BLOCKED:  next_st.relay = st.held;
      default:                    next_st.relay = '0;
    endcase
    // mapped trip-check relay, or-ed so protection stays visible in service
    next_st.relay[`CTC_AR_RELAY] = next_st.relay[`CTC_AR_RELAY] | st.trip;
    next_st.led = lamp_on ? {`CTC_NLED{1'b1}} : prot_leds;
    next_st.mon = mon_signals;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.mode     <= ctc_pkg::CTC_MODE_DISABLED;
      st.ar       <= ctc_pkg::CTC_AR_IDLE;
      st.route_ok <= `CTC_ROUTE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata                    = st.rdata;
  assign relay_drive               = st.relay;
  assign led_drive                 = st.led;
  assign monitor_out               = st.mon;
  assign reclose_trip_check_signal = st.trip;
  assign prot_disabled             = (st.mode != ctc_pkg::CTC_MODE_DISABLED);

endmodule
`default_nettype wire

// ==== verif/ctc_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module ctc_properties #(
  parameter int unsigned LAMP_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  prot_contacts,
  input wire logic [7:0]  mon_signals,
  input wire logic [7:0]  relay_drive,
  input wire logic [7:0]  led_drive,
  input wire logic [7:0]  monitor_out,
  input wire logic        reclose_trip_check_signal,
  input wire logic        prot_disabled
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  ////////////////////////////////////////////////////////////
  bad_addr_a: assert property (
    acc && paddr > 12'h01c |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mode_out_a: assert property (
    acc && pwrite && paddr == 12'h000 && pwdata[1:0] != 2'h3
    |=> prot_disabled == ($past(pwdata[1:0]) != 2'h0))
    else $error("mode flag wrong");
  cmd_clear_a: assert property (
    acc && !pwrite && paddr == 12'h008 |-> prdata == 32'h0)
    else $error("command field not cleared");
  view_a: assert property (
    acc && !pwrite && paddr == 12'h010 && prot_contacts == $past(prot_contacts)
    && prot_contacts == $past(prot_contacts, 2) |-> prdata[7:0] == prot_contacts)
    else $error("status view not intended state");
  mon_copy_a: assert property (
    $past(presetn) |-> monitor_out == $past(mon_signals))
    else $error("monitor line mismatch");
  trip_pulse_a: assert property (
    reclose_trip_check_signal |=> !reclose_trip_check_signal)
    else $error("trip check not a pulse");
  trip_relay_a: assert property (
    $rose(reclose_trip_check_signal) |-> ##[0:1] relay_drive[2])
    else $error("trip check not on relay 3");
  lamp_on_a: assert property (
    acc && pwrite && paddr == 12'h008 && pwdata[2]
    |-> ##[1:3] (led_drive == 8'hff)[*8])
    else $error("lamp test not lit");
endmodule
bind ctc_top ctc_properties #(.LAMP_CYC(LAMP_CYC)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .prot_contacts(prot_contacts),
  .mon_signals(mon_signals), .relay_drive(relay_drive), .led_drive(led_drive),
  .monitor_out(monitor_out), .reclose_trip_check_signal(reclose_trip_check_signal),
  .prot_disabled(prot_disabled));
`default_nettype wire

// ==== verif/ctc_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
module ctc_partner (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       slow,
  input wire logic       alarm_en,
  input wire logic       trip,
  input wire logic [7:0] monitor_out,
  output logic           done,
  output logic [7:0]     lamps,
  output logic           alarm
);
  logic [5:0] cnt;
  // sequencer finishes quickly or slowly after each trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 6'h0;
      done <= 1'b0;
    end else begin
      done <= (cnt == 6'h1);
      if (trip) cnt <= slow ? 6'h20 : 6'h3;
      else if (cnt != 6'h0) cnt <= cnt - 6'h1;
    end
  end
  assign lamps = monitor_out;
  assign alarm = alarm_en && (|monitor_out);
endmodule
`default_nettype wire

// ==== verif/commissioning_test_control_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module commissioning_test_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, err, perr, slow, trip, done, avail;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] prot, leds, mon, relay_drive, led_drive, monitor_out;
  int fail_count = 0;
  int num_checks = 0;
  int trips = 0;
  ctc_top #(.LAMP_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(err), .prot_contacts(prot), .prot_leds(leds),
    .mon_signals(mon), .reclose_trip_done(done), .reclose_avail(avail),
    .relay_drive(relay_drive), .led_drive(led_drive), .monitor_out(monitor_out),
    .reclose_trip_check_signal(trip), .prot_disabled());
  ctc_partner u_far (.pclk(pclk), .presetn(presetn), .slow(slow), .alarm_en(1'b1),
    .trip(trip), .monitor_out(monitor_out), .done(done), .lamps(), .alarm());
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (trip === 1'b1) trips++;
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      fail_count++;
      final_report;
    end
    q = prdata;
    perr = err;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(0, 12'h000, 0);
    chk("mode", q, 0);
    chk("mode err", perr, 0);
    apb(0, 12'h01c, 0);
    chk("route", q, 1);
    apb(0, 12'h020, 0);
    chk("unmapped", q, 0);
    chk("slverr", perr, 1);
  endtask
  task automatic t_contacts;
    apb(1, 12'h004, 32'h5a);
    apb(0, 12'h004, 0);
    chk("pattern off", q, 0);
    apb(1, 12'h008, 1);
    repeat (2) @(posedge pclk);
    chk("relay off", relay_drive, 8'h0f);
    apb(1, 12'h000, 2);
    apb(1, 12'h004, 32'h5a);
    apb(0, 12'h004, 0);
    chk("pattern", q, 32'h5a);
    apb(1, 12'h008, 1);
    repeat (2) @(posedge pclk);
    chk("apply", relay_drive, 8'h5a);
    apb(0, 12'h008, 0);
    chk("cmd apply", q, 0);
    apb(0, 12'h00c, 0);
    chk("held", q[2], 1);
    repeat (8) @(posedge pclk);
    chk("hold", relay_drive, 8'h5a);
    apb(0, 12'h010, 0);
    chk("view", q, 32'h0f);
    apb(1, 12'h008, 2);
    repeat (2) @(posedge pclk);
    chk("remove", relay_drive, 0);
    apb(0, 12'h008, 0);
    chk("cmd remove", q, 0);
    apb(1, 12'h000, 0);
    repeat (2) @(posedge pclk);
    chk("in service", relay_drive, 8'h0f);
  endtask
  task automatic t_lamp;
    apb(1, 12'h008, 4);
    repeat (2) @(posedge pclk);
    chk("lamp on", led_drive, 8'hff);
    apb(0, 12'h00c, 0);
    chk("lamp st", q[0], 1);
    repeat (30) @(posedge pclk);
    chk("lamp off", led_drive, 8'h24);
  endtask
  task automatic t_reclose;
    slow <= 1'b1;
    apb(1, 12'h008, 8);
    repeat (4) @(posedge pclk);
    chk("trip", trips, 1);
    apb(0, 12'h00c, 0);
    chk("busy", q[1], 1);
    apb(1, 12'h008, 8);
    repeat (40) @(posedge pclk);
    chk("ignored", trips, 1);
    slow <= 1'b0;
    apb(1, 12'h008, 8);
    repeat (10) @(posedge pclk);
    chk("next", trips, 2);
    apb(1, 12'h01c, 0);
    apb(1, 12'h008, 8);
    repeat (10) @(posedge pclk);
    chk("unrouted", trips, 2);
  endtask
  task automatic t_mon;
    mon <= 8'h81;
    repeat (2) @(posedge pclk);
    chk("monitor", monitor_out, 8'h81);
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    prot = 8'h0f; leds = 8'h24; mon = 8'h00; avail = 1'b1; slow = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_contacts;
    t_lamp;
    t_reclose;
    t_mon;
    final_report;
  end
endmodule
`default_nettype wire
